// >>> src/liord_params.svh
`ifndef LIORD_PARAMS_SVH
`define LIORD_PARAMS_SVH
`define LIORD_OFS_RES_B 8'h60
`define LIORD_OFS_RES_C 8'h64
`define LIORD_OFS_RES_E 8'h68
`define LIORD_RST_RES_B 32'h00000000
`define LIORD_RST_RES_C 32'h00000000
`define LIORD_RST_RES_E 24'h000000
`define LIORD_WMASK_RES_B 32'hF7FFFFFF
`define LIORD_WMASK_RES_C 32'hFFEFFFFF
`define LIORD_WMASK_RES_E 24'h1FFFFF
`define LIORD_B_JOY_FWD 31
`define LIORD_B_KBD_FWD 30
`define LIORD_B_FDC_FWD 29
`define LIORD_B_FDC_SEL 28
`define LIORD_B_LPT_SEL_LSB 25
`define LIORD_B_SND_FWD 24
`define LIORD_B_MUS_FWD 20
`define LIORD_GEN_CS 23
`define LIORD_GEN_FWD 22
`define LIORD_GEN_MON 21
`define LIORD_GEN_MASK_LSB 16
`define LIORD_E_MON 20
`define LIORD_C_SERB_FWD 31
`define LIORD_C_SERB_SEL_LSB 28
`define LIORD_C_SERA_FWD 27
`define LIORD_C_SERA_SEL_LSB 24
`define LIORD_CMD_IO_RD 4'h2
`define LIORD_CMD_IO_WR 4'h3
`define LIORD_PIN_RST 22'h3F0000
`define LIORD_JOY_LO 16'h0200
`define LIORD_JOY_HI 16'h0207
`define LIORD_KBD_DATA 16'h0060
`define LIORD_KBD_CMD 16'h0064
`define LIORD_FDC_PRI_LO 16'h03F0
`define LIORD_FDC_PRI_HI 16'h03F5
`define LIORD_FDC_PRI_X 16'h03F7
`define LIORD_FDC_SEC_LO 16'h0370
`define LIORD_FDC_SEC_HI 16'h0375
`define LIORD_FDC_SEC_X 16'h0377
`define LIORD_LPT0_LO 16'h03BC
`define LIORD_LPT0_HI 16'h03BF
`define LIORD_LPT0_XLO 16'h07BC
`define LIORD_LPT0_XHI 16'h07BE
`define LIORD_LPT1_LO 16'h0378
`define LIORD_LPT1_HI 16'h037F
`define LIORD_LPT1_XLO 16'h0778
`define LIORD_LPT1_XHI 16'h077A
`define LIORD_LPT2_LO 16'h0278
`define LIORD_LPT2_HI 16'h027F
`define LIORD_LPT2_XLO 16'h0678
`define LIORD_LPT2_XHI 16'h067A
`define LIORD_SND_BASE0 16'h0530
`define LIORD_SND_BASE1 16'h0604
`define LIORD_SND_BASE2 16'h0E80
`define LIORD_SND_BASE3 16'h0F40
`define LIORD_MUS_BASE0 16'h0300
`define LIORD_MUS_BASE1 16'h0310
`define LIORD_MUS_BASE2 16'h0320
`define LIORD_MUS_BASE3 16'h0330
`define LIORD_SER_BASE0 16'h03F8
`define LIORD_SER_BASE1 16'h02F8
`define LIORD_SER_BASE2 16'h0220
`define LIORD_SER_BASE3 16'h0228
`define LIORD_SER_BASE4 16'h0238
`define LIORD_SER_BASE5 16'h02E8
`define LIORD_SER_BASE6 16'h0338
`define LIORD_SER_BASE7 16'h03E8
`define LIORD_LAST8 16'h0007
`define LIORD_LAST4 16'h0003
`endif

// >>> src/liord_pkg.sv
package liord_pkg;
    typedef enum logic [1:0] {LIORD_IDLE, LIORD_ADDR, LIORD_BUSY} liord_phase_t;
    typedef enum logic [3:0] {
        LIORD_TGT_NONE, LIORD_TGT_JOYSTICK, LIORD_TGT_KEYBOARD, LIORD_TGT_FLOPPY,
        LIORD_TGT_PARALLEL, LIORD_TGT_SOUND, LIORD_TGT_MUSIC, LIORD_TGT_SERIAL_A,
        LIORD_TGT_SERIAL_B, LIORD_TGT_GENERIC_A, LIORD_TGT_GENERIC_B, LIORD_TGT_GENERIC_C
    } liord_target_t;
    typedef struct packed {
        logic [31:0] res_b;
        logic [31:0] res_c;
        logic [23:0] res_e;
        logic [31:0] rdata;
        logic ack;
        logic frame_prev;
        liord_phase_t phase;
        logic claim;
        liord_target_t target;
        logic cs_a_n;
        logic cs_b_n;
    } liord_state_t;
endpackage

// >>> src/liord_sync.sv
`timescale 1ns/1ps
`default_nettype none
module liord_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } liord_sync_state_t;

    liord_sync_state_t st_ff;
    liord_sync_state_t nxt_st;

    // A bit of the output follows only once the second and third stages agree.
    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = din;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        nxt_st.q = (st_ff.s2 & st_ff.s3) | (st_ff.q & (st_ff.s2 | st_ff.s3));
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff.s1 <= RST_VAL;
            st_ff.s2 <= RST_VAL;
            st_ff.s3 <= RST_VAL;
            st_ff.q <= RST_VAL;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign dout = st_ff.q;
endmodule
`default_nettype wire

// >>> src/liord_range_match.sv
`timescale 1ns/1ps
`default_nettype none
module liord_range_match (
    input wire logic [15:0] addr,
    input wire logic [15:0] base,
    input wire logic [3:0] mask,
    output logic hit
);
    // Upper bits compare exactly; a set mask bit drops that low bit from the compare.
    assign hit = (addr[15:4] == base[15:4]) && (((addr[3:0] ^ base[3:0]) & ~mask) == 4'h0);
endmodule
`default_nettype wire

// >>> src/liord_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "liord_params.svh"
module liord_decoder #(
    parameter logic [15:0] EC_DATA_PORT = 16'h0062,
    parameter logic [15:0] EC_CMD_PORT = 16'h0066
) (
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic PCI_FRAME_N,
    input wire logic PCI_IRDY_N,
    input wire logic [3:0] PCI_CBE_N,
    input wire logic [15:0] PCI_AD,
    input wire logic CFG_SEL,
    input wire logic CFG_WR,
    input wire logic [7:0] CFG_ADDR,
    input wire logic [3:0] CFG_BE,
    input wire logic [31:0] CFG_WDATA,
    output logic [31:0] CFG_RDATA,
    output logic CFG_ACK,
    input wire logic JOYSTICK_DECODE_ENABLE,
    input wire logic KEYBOARD_DECODE_ENABLE,
    input wire logic FLOPPY_MONITOR_ENABLE,
    input wire logic PARALLEL_MONITOR_ENABLE,
    input wire logic PARALLEL_FORWARD_ENABLE,
    input wire logic SOUND_SYSTEM_DECODE_ENABLE,
    input wire logic [1:0] SOUND_SYSTEM_RANGE_SELECT,
    input wire logic MUSIC_PORT_DECODE_ENABLE,
    input wire logic [1:0] MUSIC_PORT_RANGE_SELECT,
    input wire logic EMBEDDED_CTRL_DECODE_ENABLE,
    input wire logic SERIAL_A_MONITOR_ENABLE,
    input wire logic SERIAL_B_MONITOR_ENABLE,
    input wire logic GENERIC_C_FORWARD_ENABLE,
    output logic IO_CLAIM,
    output logic [3:0] IO_TARGET,
    output logic PROG_CHIP_SELECT_A_N,
    output logic PROG_CHIP_SELECT_B_N
);
    liord_pkg::liord_state_t st_ff;
    liord_pkg::liord_state_t nxt_st;

    logic [21:0] pin_q;
    logic frame_n;
    logic irdy_n;
    logic [3:0] cbe_n;
    logic [15:0] adr;
    logic gen_a_match;
    logic gen_b_match;
    logic gen_c_match;
    logic [31:0] res_b;
    logic [31:0] res_c;
    logic [23:0] res_e;

    function automatic logic win(input logic [15:0] a, input logic [15:0] lo,
                                 input logic [15:0] hi);
        win = (a >= lo) && (a <= hi);
    endfunction

    function automatic logic blk(input logic [15:0] a, input logic [15:0] base,
                                 input logic [15:0] last);
        logic [15:0] top;
        top = base + last;
        blk = (a >= base) && (a <= top);
    endfunction

    function automatic logic [15:0] ser_base(input logic [2:0] sel);
        case (sel)
            3'h0: ser_base = `LIORD_SER_BASE0;
            3'h1: ser_base = `LIORD_SER_BASE1;
            3'h2: ser_base = `LIORD_SER_BASE2;
            3'h3: ser_base = `LIORD_SER_BASE3;
            3'h4: ser_base = `LIORD_SER_BASE4;
            3'h5: ser_base = `LIORD_SER_BASE5;
            3'h6: ser_base = `LIORD_SER_BASE6;
            default: ser_base = `LIORD_SER_BASE7;
        endcase
    endfunction

    function automatic logic [15:0] snd_base(input logic [1:0] sel);
        case (sel)
            2'h0: snd_base = `LIORD_SND_BASE0;
            2'h1: snd_base = `LIORD_SND_BASE1;
            2'h2: snd_base = `LIORD_SND_BASE2;
            default: snd_base = `LIORD_SND_BASE3;
        endcase
    endfunction

    function automatic logic [15:0] mus_base(input logic [1:0] sel);
        case (sel)
            2'h0: mus_base = `LIORD_MUS_BASE0;
            2'h1: mus_base = `LIORD_MUS_BASE1;
            2'h2: mus_base = `LIORD_MUS_BASE2;
            default: mus_base = `LIORD_MUS_BASE3;
        endcase
    endfunction

    function automatic logic lpt_match(input logic [15:0] a, input logic [1:0] sel);
        case (sel)
            2'h0: lpt_match = win(a, `LIORD_LPT0_LO, `LIORD_LPT0_HI) ||
                              win(a, `LIORD_LPT0_XLO, `LIORD_LPT0_XHI);
            2'h1: lpt_match = win(a, `LIORD_LPT1_LO, `LIORD_LPT1_HI) ||
                              win(a, `LIORD_LPT1_XLO, `LIORD_LPT1_XHI);
            2'h2: lpt_match = win(a, `LIORD_LPT2_LO, `LIORD_LPT2_HI) ||
                              win(a, `LIORD_LPT2_XLO, `LIORD_LPT2_XHI);
            default: lpt_match = 1'b0;
        endcase
    endfunction

    function automatic logic fdc_match(input logic [15:0] a, input logic secondary);
        if (secondary) begin
            fdc_match = win(a, `LIORD_FDC_SEC_LO, `LIORD_FDC_SEC_HI) ||
                        (a == `LIORD_FDC_SEC_X);
        end else begin
            fdc_match = win(a, `LIORD_FDC_PRI_LO, `LIORD_FDC_PRI_HI) ||
                        (a == `LIORD_FDC_PRI_X);
        end
    endfunction

    // Bus pins come from the PCI clock domain and are filtered before use.
    liord_sync #(
        .W(22),
        .RST_VAL(`LIORD_PIN_RST)
    ) u_pin_sync (
        .clk(SYS_CLK),
        .rst_n(NRST),
        .din({PCI_FRAME_N, PCI_IRDY_N, PCI_CBE_N, PCI_AD}),
        .dout(pin_q)
    );

    assign frame_n = pin_q[21];
    assign irdy_n = pin_q[20];
    assign cbe_n = pin_q[19:16];
    assign adr = pin_q[15:0];
    assign res_b = st_ff.res_b;
    assign res_c = st_ff.res_c;
    assign res_e = st_ff.res_e;

    liord_range_match u_gen_a (
        .addr(adr),
        .base(res_b[15:0]),
        .mask(res_b[`LIORD_GEN_MASK_LSB +: 4]),
        .hit(gen_a_match)
    );

    liord_range_match u_gen_b (
        .addr(adr),
        .base(res_c[15:0]),
        .mask(res_c[`LIORD_GEN_MASK_LSB +: 4]),
        .hit(gen_b_match)
    );

    liord_range_match u_gen_c (
        .addr(adr),
        .base(res_e[15:0]),
        .mask(res_e[`LIORD_GEN_MASK_LSB +: 4]),
        .hit(gen_c_match)
    );

    always_comb begin
        logic [31:0] bm;
        logic io_cmd;
        logic joy_hit;
        logic kbd_hit;
        logic fdc_hit;
        logic lpt_hit;
        logic snd_hit;
        logic mus_hit;
        logic ser_a_hit;
        logic ser_b_hit;
        logic gen_a_io;
        logic ec_io;
        logic gen_a_hit;
        logic gen_b_io;
        logic gen_b_hit;
        logic gen_c_hit;
        logic cs_a;
        logic cs_b;
        liord_pkg::liord_target_t tgt;
        bm = {{8{CFG_BE[3]}}, {8{CFG_BE[2]}}, {8{CFG_BE[1]}}, {8{CFG_BE[0]}}};
        io_cmd = (cbe_n == `LIORD_CMD_IO_RD) || (cbe_n == `LIORD_CMD_IO_WR);
        joy_hit = res_b[`LIORD_B_JOY_FWD] && JOYSTICK_DECODE_ENABLE &&
                  win(adr, `LIORD_JOY_LO, `LIORD_JOY_HI);
        kbd_hit = res_b[`LIORD_B_KBD_FWD] && KEYBOARD_DECODE_ENABLE &&
                  ((adr == `LIORD_KBD_DATA) || (adr == `LIORD_KBD_CMD));
        fdc_hit = res_b[`LIORD_B_FDC_FWD] && FLOPPY_MONITOR_ENABLE &&
                  fdc_match(adr, res_b[`LIORD_B_FDC_SEL]);
        lpt_hit = PARALLEL_FORWARD_ENABLE && PARALLEL_MONITOR_ENABLE &&
                  lpt_match(adr, res_b[`LIORD_B_LPT_SEL_LSB +: 2]);
        snd_hit = res_b[`LIORD_B_SND_FWD] && SOUND_SYSTEM_DECODE_ENABLE &&
                  blk(adr, snd_base(SOUND_SYSTEM_RANGE_SELECT), `LIORD_LAST8);
        mus_hit = res_b[`LIORD_B_MUS_FWD] && MUSIC_PORT_DECODE_ENABLE &&
                  blk(adr, mus_base(MUSIC_PORT_RANGE_SELECT), `LIORD_LAST4);
        ser_b_hit = res_c[`LIORD_C_SERB_FWD] && SERIAL_B_MONITOR_ENABLE &&
                    blk(adr, ser_base(res_c[`LIORD_C_SERB_SEL_LSB +: 3]), `LIORD_LAST8);
        ser_a_hit = res_c[`LIORD_C_SERA_FWD] && SERIAL_A_MONITOR_ENABLE &&
                    blk(adr, ser_base(res_c[`LIORD_C_SERA_SEL_LSB +: 3]), `LIORD_LAST8);
        gen_a_io = res_b[`LIORD_GEN_MON] && gen_a_match;
        ec_io = EMBEDDED_CTRL_DECODE_ENABLE && ((adr == EC_DATA_PORT) || (adr == EC_CMD_PORT));
        gen_a_hit = res_b[`LIORD_GEN_FWD] && (gen_a_io || ec_io);
        cs_a = res_b[`LIORD_GEN_CS] && res_b[`LIORD_GEN_FWD] && gen_a_io;
        gen_b_io = res_c[`LIORD_GEN_MON] && gen_b_match;
        gen_b_hit = res_c[`LIORD_GEN_FWD] && gen_b_io;
        cs_b = res_c[`LIORD_GEN_CS] && res_c[`LIORD_GEN_FWD] && gen_b_io;
        gen_c_hit = GENERIC_C_FORWARD_ENABLE && res_e[`LIORD_E_MON] && gen_c_match;
        if (joy_hit) begin
            tgt = liord_pkg::LIORD_TGT_JOYSTICK;
        end else if (kbd_hit) begin
            tgt = liord_pkg::LIORD_TGT_KEYBOARD;
        end else if (fdc_hit) begin
            tgt = liord_pkg::LIORD_TGT_FLOPPY;
        end else if (lpt_hit) begin
            tgt = liord_pkg::LIORD_TGT_PARALLEL;
        end else if (snd_hit) begin
            tgt = liord_pkg::LIORD_TGT_SOUND;
        end else if (mus_hit) begin
            tgt = liord_pkg::LIORD_TGT_MUSIC;
        end else if (ser_a_hit) begin
            tgt = liord_pkg::LIORD_TGT_SERIAL_A;
        end else if (ser_b_hit) begin
            tgt = liord_pkg::LIORD_TGT_SERIAL_B;
        end else if (gen_a_hit) begin
            tgt = liord_pkg::LIORD_TGT_GENERIC_A;
        end else if (gen_b_hit) begin
            tgt = liord_pkg::LIORD_TGT_GENERIC_B;
        end else if (gen_c_hit) begin
            tgt = liord_pkg::LIORD_TGT_GENERIC_C;
        end else begin
            tgt = liord_pkg::LIORD_TGT_NONE;
        end

        nxt_st = st_ff;
        nxt_st.ack = 1'b0;
        nxt_st.frame_prev = frame_n;
        if (CFG_SEL) begin
            nxt_st.ack = 1'b1;
            nxt_st.rdata = 32'h00000000;
            if (CFG_WR) begin
                case (CFG_ADDR)
                    `LIORD_OFS_RES_B: begin
                        nxt_st.res_b = (res_b & ~(bm & `LIORD_WMASK_RES_B)) |
                                       (CFG_WDATA & bm & `LIORD_WMASK_RES_B);
                    end
                    `LIORD_OFS_RES_C: begin
                        nxt_st.res_c = (res_c & ~(bm & `LIORD_WMASK_RES_C)) |
                                       (CFG_WDATA & bm & `LIORD_WMASK_RES_C);
                    end
                    `LIORD_OFS_RES_E: begin
                        nxt_st.res_e = (res_e & ~(bm[23:0] & `LIORD_WMASK_RES_E)) |
                                       (CFG_WDATA[23:0] & bm[23:0] & `LIORD_WMASK_RES_E);
                    end
                    default: begin
                    end
                endcase
            end else begin
                case (CFG_ADDR)
                    `LIORD_OFS_RES_B: nxt_st.rdata = res_b;
                    `LIORD_OFS_RES_C: nxt_st.rdata = res_c;
                    `LIORD_OFS_RES_E: nxt_st.rdata = {8'h00, res_e};
                    default: nxt_st.rdata = 32'h00000000;
                endcase
            end
        end

        // decode one cycle after the frame falls, so the address has settled.
        case (st_ff.phase)
            liord_pkg::LIORD_IDLE: begin
                if (st_ff.frame_prev && !frame_n) begin
                    nxt_st.phase = liord_pkg::LIORD_ADDR;
                end
            end
            liord_pkg::LIORD_ADDR: begin
                if (io_cmd && (tgt != liord_pkg::LIORD_TGT_NONE)) begin
                    nxt_st.claim = 1'b1;
                    nxt_st.target = tgt;
                    nxt_st.cs_a_n = !cs_a;
                    nxt_st.cs_b_n = !cs_b;
                    nxt_st.phase = liord_pkg::LIORD_BUSY;
                end else begin
                    nxt_st.phase = liord_pkg::LIORD_IDLE;
                end
            end
            liord_pkg::LIORD_BUSY: begin
                if (frame_n && irdy_n) begin
                    nxt_st.claim = 1'b0;
                    nxt_st.target = liord_pkg::LIORD_TGT_NONE;
                    nxt_st.cs_a_n = 1'b1;
                    nxt_st.cs_b_n = 1'b1;
                    nxt_st.phase = liord_pkg::LIORD_IDLE;
                end
            end
            default: begin
                nxt_st.phase = liord_pkg::LIORD_IDLE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            st_ff.res_b <= `LIORD_RST_RES_B;
            st_ff.res_c <= `LIORD_RST_RES_C;
            st_ff.res_e <= `LIORD_RST_RES_E;
            st_ff.rdata <= 32'h00000000;
            st_ff.ack <= 1'b0;
            st_ff.frame_prev <= 1'b1;
            st_ff.phase <= liord_pkg::LIORD_IDLE;
            st_ff.claim <= 1'b0;
            st_ff.target <= liord_pkg::LIORD_TGT_NONE;
            st_ff.cs_a_n <= 1'b1;
            st_ff.cs_b_n <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign CFG_RDATA = st_ff.rdata;
    assign CFG_ACK = st_ff.ack;
    assign IO_CLAIM = st_ff.claim;
    assign IO_TARGET = st_ff.target;
    assign PROG_CHIP_SELECT_A_N = st_ff.cs_a_n;
    assign PROG_CHIP_SELECT_B_N = st_ff.cs_b_n;
endmodule
`default_nettype wire

// >>> tb/liord_decoder_chk.sv
`timescale 1ns/1ps
`default_nettype none
module liord_chk (
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic PCI_FRAME_N,
    input wire logic PCI_IRDY_N,
    input wire logic [3:0] PCI_CBE_N,
    input wire logic CFG_SEL,
    input wire logic CFG_WR,
    input wire logic [31:0] CFG_RDATA,
    input wire logic CFG_ACK,
    input wire logic IO_CLAIM,
    input wire logic [3:0] IO_TARGET,
    input wire logic PROG_CHIP_SELECT_A_N,
    input wire logic PROG_CHIP_SELECT_B_N
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);
    sequence s_bus_idle;
        (PCI_FRAME_N && PCI_IRDY_N) [*7];
    endsequence
    sequence s_in_frame;
        IO_CLAIM && (!PCI_FRAME_N || !PCI_IRDY_N);
    endsequence
    property p_ack; CFG_SEL |=> CFG_ACK; endproperty
    property p_no_ack; !CFG_SEL |=> !CFG_ACK; endproperty
    property p_wr_zero; CFG_SEL && CFG_WR |=> CFG_RDATA == 32'h0; endproperty
    property p_claim_cause;
        $rose(IO_CLAIM) |-> $past(PCI_FRAME_N, 4) == 1'b0 && $past(PCI_CBE_N, 4) inside {4'h2, 4'h3};
    endproperty
    property p_claim_tgt; IO_CLAIM |-> IO_TARGET != 4'h0; endproperty
    property p_cs_a; !PROG_CHIP_SELECT_A_N |-> IO_CLAIM; endproperty
    property p_cs_b; !PROG_CHIP_SELECT_B_N |-> IO_CLAIM; endproperty
    property p_release;
        s_bus_idle |-> !IO_CLAIM && PROG_CHIP_SELECT_A_N && PROG_CHIP_SELECT_B_N;
    endproperty
    property p_hold; s_in_frame |=> IO_CLAIM && $stable(IO_TARGET); endproperty
    a_ack: assert property (p_ack) else $error("config ack missing");
    a_no_ack: assert property (p_no_ack) else $error("config ack without select");
    a_wr_zero: assert property (p_wr_zero) else $error("read data not zero after write");
    a_claim_cause: assert property (p_claim_cause) else $error("claim without io frame");
    a_claim_tgt: assert property (p_claim_tgt) else $error("claim with no target");
    a_cs_a: assert property (p_cs_a) else $error("chip select a outside claim");
    a_cs_b: assert property (p_cs_b) else $error("chip select b outside claim");
    a_release: assert property (p_release) else $error("claim not released");
    a_hold: assert property (p_hold) else $error("claim changed in frame");
endmodule
bind liord_decoder liord_chk u_chk (.SYS_CLK(SYS_CLK), .NRST(NRST), .PCI_FRAME_N(PCI_FRAME_N),
    .PCI_IRDY_N(PCI_IRDY_N), .PCI_CBE_N(PCI_CBE_N), .CFG_SEL(CFG_SEL), .CFG_WR(CFG_WR),
    .CFG_RDATA(CFG_RDATA), .CFG_ACK(CFG_ACK), .IO_CLAIM(IO_CLAIM), .IO_TARGET(IO_TARGET),
    .PROG_CHIP_SELECT_A_N(PROG_CHIP_SELECT_A_N), .PROG_CHIP_SELECT_B_N(PROG_CHIP_SELECT_B_N));
`default_nettype wire

// >>> tb/liord_host.sv
`timescale 1ns/1ps
`default_nettype none
module liord_host (
    input wire logic clk,
    output logic frame_n,
    output logic irdy_n,
    output logic [3:0] cbe_n,
    output logic [15:0] ad
);
    initial begin
        frame_n = 1'b1;
        irdy_n = 1'b1;
        cbe_n = 4'hF;
        ad = 16'h0;
    end
    // A released bus keeps moving so stale address values cannot match.
    always @(posedge clk) begin
        if (frame_n && irdy_n) begin
            ad <= ~ad;
        end
    end
    task automatic run(input logic [3:0] cmd, input logic [15:0] addr);
        @(posedge clk);
        #1;
        frame_n = 1'b0;
        cbe_n = cmd;
        ad = addr;
        repeat (10) @(posedge clk);
        #1;
        frame_n = 1'b1;
        irdy_n = 1'b0;
        cbe_n = 4'h0;
        ad = ~addr;
        repeat (8) @(posedge clk);
        #1;
        irdy_n = 1'b1;
        cbe_n = ~cmd;
        repeat (6) @(posedge clk);
        #1;
    endtask
endmodule
`default_nettype wire

// >>> tb/test_legacy_io_resource_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "liord_params.svh"
module test_legacy_io_resource_decoder;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic frame_n;
    logic irdy_n;
    logic [3:0] cbe_n;
    logic [15:0] ad;
    logic cfg_sel = 1'b0;
    logic cfg_wr = 1'b0;
    logic [7:0] cfg_addr = 8'h00;
    logic [3:0] cfg_be = 4'h0;
    logic [31:0] cfg_wdata = 32'h0;
    logic [31:0] cfg_rdata;
    logic cfg_ack;
    // Enables: joy kbd fdc lptmon lptfwd snd mus ec sera serb genc, from bit 0 up.
    logic [10:0] en = 11'h0;
    logic [1:0] snd_sel = 2'h0;
    logic [1:0] mus_sel = 2'h0;
    logic io_claim;
    logic [3:0] io_target;
    logic cs_a_n;
    logic cs_b_n;
    int errors = 0;
    int n_checks = 0;
    always #2.5 sys_clk = ~sys_clk;
    liord_host u_host (.clk(sys_clk), .frame_n(frame_n), .irdy_n(irdy_n), .cbe_n(cbe_n), .ad(ad));
    liord_decoder i_dut (.SYS_CLK(sys_clk), .NRST(nrst), .PCI_FRAME_N(frame_n),
        .PCI_IRDY_N(irdy_n), .PCI_CBE_N(cbe_n), .PCI_AD(ad), .CFG_SEL(cfg_sel), .CFG_WR(cfg_wr),
        .CFG_ADDR(cfg_addr), .CFG_BE(cfg_be), .CFG_WDATA(cfg_wdata), .CFG_RDATA(cfg_rdata),
        .CFG_ACK(cfg_ack), .JOYSTICK_DECODE_ENABLE(en[0]), .KEYBOARD_DECODE_ENABLE(en[1]),
        .FLOPPY_MONITOR_ENABLE(en[2]), .PARALLEL_MONITOR_ENABLE(en[3]),
        .PARALLEL_FORWARD_ENABLE(en[4]), .SOUND_SYSTEM_DECODE_ENABLE(en[5]),
        .SOUND_SYSTEM_RANGE_SELECT(snd_sel), .MUSIC_PORT_DECODE_ENABLE(en[6]),
        .MUSIC_PORT_RANGE_SELECT(mus_sel), .EMBEDDED_CTRL_DECODE_ENABLE(en[7]),
        .SERIAL_A_MONITOR_ENABLE(en[8]), .SERIAL_B_MONITOR_ENABLE(en[9]),
        .GENERIC_C_FORWARD_ENABLE(en[10]), .IO_CLAIM(io_claim), .IO_TARGET(io_target),
        .PROG_CHIP_SELECT_A_N(cs_a_n), .PROG_CHIP_SELECT_B_N(cs_b_n));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cfg(input logic wr, input logic [7:0] a, input logic [3:0] be,
                       input logic [31:0] wd, input logic [31:0] exp);
        @(posedge sys_clk);
        #1;
        cfg_sel = 1'b1;
        cfg_wr = wr;
        cfg_addr = a;
        cfg_be = be;
        cfg_wdata = wd;
        @(posedge sys_clk);
        #1;
        cfg_sel = 1'b0;
        check("cfg_ack", 32'h1, {31'h0, cfg_ack});
        if (!wr) check("cfg_rdata", exp, cfg_rdata);
    endtask
    task automatic io(input logic [15:0] a, input logic [3:0] tgt, input logic csa = 1'b1,
                      input logic csb = 1'b1, input logic [3:0] cmd = `LIORD_CMD_IO_RD);
        fork
            u_host.run(cmd, a);
            begin
                repeat (14) @(posedge sys_clk);
                #1;
                check("io_claim", {31'h0, tgt != 4'h0}, {31'h0, io_claim});
                check("io_target", {28'h0, tgt}, {28'h0, io_target});
                check("cs_a_n", {31'h0, csa}, {31'h0, cs_a_n});
                check("cs_b_n", {31'h0, csb}, {31'h0, cs_b_n});
            end
        join
    endtask
    task automatic t_regs();
        logic [7:0] a [3] = '{8'h60, 8'h64, 8'h68};
        logic [31:0] m [3] = '{`LIORD_WMASK_RES_B, `LIORD_WMASK_RES_C, {8'h0, `LIORD_WMASK_RES_E}};
        for (int i = 0; i < 3; i++) begin
            cfg(1'b0, a[i], 4'hF, 32'h0, 32'h0);
            cfg(1'b1, a[i], 4'hF, 32'hFFFFFFFF, 32'h0);
            cfg(1'b0, a[i], 4'hF, 32'h0, m[i]);
        end
        cfg(1'b1, 8'h60, 4'h2, 32'h0, 32'h0);
        cfg(1'b0, 8'h60, 4'hF, 32'h0, `LIORD_WMASK_RES_B & 32'hFFFF00FF);
        cfg(1'b1, 8'h6C, 4'hF, 32'hFFFFFFFF, 32'h0);
        cfg(1'b0, 8'h6C, 4'hF, 32'h0, 32'h0);
        for (int i = 0; i < 3; i++) cfg(1'b1, a[i], 4'hF, 32'h0, 32'h0);
        $display("registers done");
    endtask
    task automatic t_fixed();
        logic [15:0] lpt [4] = '{16'h07BE, 16'h037F, 16'h067A, 16'h0278};
        logic [15:0] snd [4] = '{16'h0537, 16'h060B, 16'h0E87, 16'h0F47};
        cfg(1'b1, 8'h60, 4'hF, 32'hE1100000, 32'h0);
        io(16'h0207, 4'h0);
        en[0] = 1'b1;
        io(16'h0207, 4'h1);
        io(16'h0208, 4'h0);
        io(16'h0064, 4'h0);
        en[1] = 1'b1;
        io(16'h0060, 4'h2, 1'b1, 1'b1, `LIORD_CMD_IO_WR);
        io(16'h0064, 4'h2);
        io(16'h03F7, 4'h0);
        en[2] = 1'b1;
        io(16'h03F7, 4'h3);
        io(16'h03F6, 4'h0);
        cfg(1'b1, 8'h60, 4'hF, 32'hF1100000, 32'h0);
        io(16'h0370, 4'h3);
        io(16'h03F0, 4'h0);
        en[4:3] = 2'b11;
        for (int i = 0; i < 4; i++) begin
            cfg(1'b1, 8'h60, 4'hF, 32'hE1100000 | (i << 25), 32'h0);
            io(lpt[i], (i == 3) ? 4'h0 : 4'h4);
        end
        en[5] = 1'b1;
        for (int i = 0; i < 4; i++) begin
            snd_sel = 2'(i);
            io(snd[i], 4'h5);
        end
        en[6] = 1'b1;
        mus_sel = 2'h3;
        io(16'h0333, 4'h6);
        io(16'h0334, 4'h0);
        $display("fixed ranges done");
    endtask
    task automatic t_serial();
        logic [15:0] sb [8] = '{16'h03F8, 16'h02F8, 16'h0220, 16'h0228,
                                16'h0238, 16'h02E8, 16'h0338, 16'h03E8};
        en = 11'h300;
        for (int i = 0; i < 8; i++) begin
            cfg(1'b1, 8'h64, 4'hF, {1'b0, 3'(7 - i), 1'b1, 3'(i), 24'h0}, 32'h0);
            io(sb[i] + 16'h7, 4'h7);
            cfg(1'b1, 8'h64, 4'hF, {1'b1, 3'(i), 1'b0, 3'(i), 24'h0}, 32'h0);
            io(sb[i], 4'h8);
        end
        en[9] = 1'b0;
        io(16'h03E8, 4'h0);
        cfg(1'b1, 8'h64, 4'hF, 32'h0, 32'h0);
        $display("serial done");
    endtask
    task automatic t_generic();
        en = 11'h480;
        cfg(1'b1, 8'h60, 4'hF, 32'h00E91230, 32'h0);
        io(16'h1231, 4'h9, 1'b0);
        io(16'h1238, 4'h9, 1'b0);
        io(16'h1232, 4'h0);
        io(16'h1330, 4'h0);
        io(16'h0062, 4'h9);
        cfg(1'b1, 8'h60, 4'hF, 32'h00691230, 32'h0);
        io(16'h1230, 4'h9);
        cfg(1'b1, 8'h60, 4'hF, 32'h00C91230, 32'h0);
        io(16'h1231, 4'h0);
        cfg(1'b1, 8'h60, 4'hF, 32'h0, 32'h0);
        cfg(1'b1, 8'h64, 4'hF, 32'h00E34440, 32'h0);
        io(16'h4443, 4'hA, 1'b1, 1'b0);
        io(16'h4444, 4'h0);
        cfg(1'b1, 8'h68, 4'hF, 32'h00105550, 32'h0);
        io(16'h5550, 4'hB);
        io(16'h5551, 4'h0);
        io(16'h5550, 4'h0, 1'b1, 1'b1, 4'h6);
        en[10] = 1'b0;
        io(16'h5550, 4'h0);
        $display("generic done");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        errors++;
        $display("mismatch watchdog expected finish seen timeout");
        tally_and_finish();
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        check("io_claim_rst", 32'h0, {31'h0, io_claim});
        #1;
        nrst = 1'b1;
        t_regs();
        t_fixed();
        t_serial();
        t_generic();
        tally_and_finish();
    end
endmodule
`default_nettype wire
